// ### verification/erf_checker.sv
// Concurrent checks on the receive frame filter ports.
`timescale 1ns/1ps
module erf_checker (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rx_valid,
  input wire logic rx_last,
  input wire logic verdict_valid,
  input wire logic verdict_accept
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////////////////////////////////////
  // Steps of a frame close and of a write.
  sequence s_last; rx_valid && rx_last; endsequence
  sequence s_aw_w; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
  property p_verdict_after_last; s_last |=> verdict_valid; endproperty
  property p_no_stray_verdict; verdict_valid |-> $past(rx_valid && rx_last); endproperty
  property p_accept_held; !verdict_valid |-> $stable(verdict_accept); endproperty
  property p_write_answer; s_aw_w |-> ##[1:3] s_axi_bvalid; endproperty
  property p_bvalid_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  property p_read_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  property p_rvalid_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  property p_no_ar_while_r; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_verdict_after_last: assert property (p_verdict_after_last) else $error("no verdict after last byte");
  a_no_stray_verdict: assert property (p_no_stray_verdict) else $error("verdict without frame end");
  a_accept_held: assert property (p_accept_held) else $error("verdict changed between frames");
  a_write_answer: assert property (p_write_answer) else $error("write response late");
  a_bvalid_hold: assert property (p_bvalid_hold) else $error("write response dropped");
  a_read_answer: assert property (p_read_answer) else $error("read data late");
  a_rvalid_hold: assert property (p_rvalid_hold) else $error("read data dropped");
  a_no_ar_while_r: assert property (p_no_ar_while_r) else $error("read address taken while busy");
endmodule : erf_checker

bind erf_filter erf_checker u_chk (.clock(clock), .arst_n(arst_n), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .rx_valid(rx_valid), .rx_last(rx_last),
  .verdict_valid(verdict_valid), .verdict_accept(verdict_accept));

// ### verification/erf_rx_model.sv
// Receive MAC model that streams frames with their check sequence.
`timescale 1ns/1ps
module erf_rx_model
  import erf_pkg::*;
(
  input wire logic clock,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_last,
  output logic pattern_checksum_match,
  output logic hash_hit,
  output logic wake_hit
);
  // Idle levels; the data line toggles when no byte is offered.
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_last = 1'b0;
    {wake_hit, hash_hit, pattern_checksum_match} = 3'b000;
  end
  // Reflected CRC-32, sent low byte first as on the wire.
  function automatic logic [31:0] crc_of(input logic [7:0] q[$]);
    logic [31:0] c;
    c = ERF_CRC_INIT;
    foreach (q[i]) begin
      c = c ^ {24'h00_0000, q[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? ((c >> 1) ^ ERF_CRC_POLY_REFL) : (c >> 1);
    end
    return ~c;
  endfunction : crc_of
  // One frame; bad flips one check bit, gap idles between bytes to act slow.
  task automatic send(input logic [7:0] q[$], input logic bad, input logic [2:0] side, input int gap);
    logic [31:0] f;
    f = crc_of(q) ^ {31'h0, bad};
    for (int i = 0; i < 4; i++) q.push_back(f[8*i +: 8]);
    @(posedge clock);
    {wake_hit, hash_hit, pattern_checksum_match} <= side;
    foreach (q[i]) begin
      rx_valid <= 1'b1;
      rx_data <= q[i];
      rx_last <= (i == q.size() - 1);
      @(posedge clock);
      if (gap > 0 && i < q.size() - 1) begin
        rx_valid <= 1'b0;
        rx_data <= ~q[i];
        repeat (gap) @(posedge clock);
      end
    end
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
    rx_data <= ~rx_data;
  endtask : send
endmodule : erf_rx_model

// ### verification/test_ethernet_rx_frame_filter.sv
// Self-checking testbench of the receive frame filter.
`timescale 1ns/1ps
module test_ethernet_rx_frame_filter
  import erf_pkg::*;
;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [31:0] s_axi_rdata, d;
  logic rx_valid, rx_last, pattern_checksum_match, hash_hit, wake_hit, verdict_valid, verdict_accept, bad;
  logic [7:0] rx_data;
  logic [7:0] q[$];
  logic [15:0] c;
  logic [47:0] st, da;
  logic [2:0] sd;
  int n_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  int n;
  int n_acc = 0;
  int lens[6] = '{14, 64, 69, 70, 71, 100};
  always #5 clock = ~clock;
  erf_filter #(.ADDR_WIDTH(8)) uut (.clock(clock), .arst_n(arst_n), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last),
    .pattern_checksum_match(pattern_checksum_match), .hash_hit(hash_hit), .wake_hit(wake_hit),
    .verdict_valid(verdict_valid), .verdict_accept(verdict_accept));
  erf_rx_model u_src (.clock(clock), .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last),
    .pattern_checksum_match(pattern_checksum_match), .hash_hit(hash_hit), .wake_hit(wake_hit));
  ////////////////////////////////////////////////////////////////////////
  // Verdict and comparison helpers.
  task automatic end_sim;
    if (n_errors == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_sim
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check
  // A hang ends the run as a failure; 400 frames need well under this.
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 100000) begin
      n_errors++;
      end_sim();
    end
  end
  // Expected decision: collection of errors first, then rejection, then any collector.
  function automatic logic exp_accept(input logic [15:0] c, input logic [47:0] da, input int n,
                                      input logic bad, input logic [2:0] sd);
    logic loc, mc, bc, sh, pm;
    loc = (da == st);
    mc = da[0];
    bc = &da;
    sh = (n <= 69);
    case (c[11:8])
      4'd1: pm = 1'b1;
      4'd2: pm = loc;
      4'd3: pm = !loc;
      4'd4: pm = mc;
      4'd5: pm = !mc;
      4'd6: pm = bc;
      4'd7: pm = !bc;
      4'd8: pm = sd[1];
      4'd9: pm = sd[2];
      default: pm = 1'b0;
    endcase
    pm = pm & (sd[0] ^ c[12]);
    if ((c[7] && bad) || (c[5] && sh)) return 1'b1;
    if ((c[6] && bad) || (c[4] && sh)) return 1'b0;
    return (c[3] && loc) || (c[2] && !loc && !mc) || (c[1] && mc) || (c[0] && bc) || (c[15] && sd[1])
      || (c[14] && sd[2]) || pm;
  endfunction : exp_accept
  ////////////////////////////////////////////////////////////////////////
  // Register bus master; each call waits one edge so no signal is set twice in a step.
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    v = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  ////////////////////////////////////////////////////////////////////////
  // Main sequence: register corners, then frames under power-up and random settings.
  initial begin
    void'($urandom(75476));
    repeat (4) @(posedge clock);
    arst_n <= 1'b1;
    rd(ERF_OFS_FILTER_CONTROL, d, r);
    check(d, 32'h0000_0059);
    wr(ERF_OFS_FILTER_CONTROL, 32'h0000_FFFF, r);
    rd(ERF_OFS_FILTER_CONTROL, d, r);
    check(d, 32'h0000_DFFF);
    rd(8'h40, d, r);
    check({30'h0, r}, 32'h0000_0002);
    check(d, 32'h0000_0000);
    wr(8'h40, 32'h0000_0000, r);
    check({30'h0, r}, 32'h0000_0002);
    st = {16'($urandom), 32'($urandom)};
    st[0] = 1'b0;
    wr(ERF_OFS_STATION_LO, st[31:0], r);
    wr(ERF_OFS_STATION_HI, {16'h0000, st[47:32]}, r);
    for (int i = 0; i < 400; i++) begin
      c = 16'h0059;
      if (i >= 40) begin
        c = 16'($urandom & $urandom);
        c[11:8] = 4'(i);
        c[13] = 1'b0;
        // Hash and wake modes must decide alone, or the plain hash filter would mask the pattern result.
        if (c[11]) c[15:14] = 2'b00;
      end
      wr(ERF_OFS_FILTER_CONTROL, {16'h0000, c}, r);
      n = lens[$urandom % 6];
      da = {16'($urandom), 32'($urandom)};
      case ($urandom % 4)
        0: da = st;
        1: da[0] = 1'b0;
        2: da[0] = 1'b1;
        default: da = '1;
      endcase
      q = {};
      for (int j = 0; j < n - 4; j++) q.push_back((j < 6) ? da[8*j +: 8] : 8'($urandom));
      bad = ($urandom % 4 == 0);
      sd = 3'($urandom);
      if (exp_accept(c, da, n, bad, sd)) n_acc++;
      u_src.send(q, bad, sd, $urandom % 3);
      #1;
      check({31'h0, verdict_valid}, 32'h0000_0001);
      check({31'h0, verdict_accept}, {31'h0, exp_accept(c, da, n, bad, sd)});
    end
    // Oversize frame to the station: without the cut it would be accepted, with it the check sequence fails.
    wr(ERF_OFS_MAX_FRAME_LENGTH, 32'h0000_0050, r);
    wr(ERF_OFS_FILTER_CONTROL, 32'h0000_0059, r);
    q = {};
    for (int j = 0; j < 96; j++) q.push_back((j < 6) ? st[8*j +: 8] : 8'($urandom));
    u_src.send(q, 1'b0, 3'b000, 0);
    #1;
    check({31'h0, verdict_accept}, 32'h0000_0000);
    // Status: accepted count, then truncated, not short, CRC bad, discarded.
    rd(ERF_OFS_STATUS, d, r);
    check(d, {16'h0000, n_acc[7:0], 8'h0A});
    end_sim();
  end
endmodule : test_ethernet_rx_frame_filter

// ### verilog/erf_filter.sv
// Receive frame filter chain with its AXI4-Lite register slave.
//
// The address map and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
module erf_filter
  import erf_pkg::*;
#(
  parameter int ADDR_WIDTH = 8,
  parameter logic [15:0] MAX_FRAME_DEFAULT = ERF_MAX_FRAME_RESET
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_last,
  input wire logic pattern_checksum_match,
  input wire logic hash_hit,
  input wire logic wake_hit,
  output logic verdict_valid,
  output logic verdict_accept
);

  ////////////////////////////////////////////////////////////////////////////
  // State of the whole block in one record.
  typedef struct packed {
    logic [15:0] rx_filter_control;
    logic [47:0] station_address;
    logic [15:0] max_frame_length;
    logic [47:0] dest;
    logic [15:0] byte_count;
    logic [31:0] crc;
    logic trunc;
    logic verdict_valid;
    logic verdict_accept;
    logic last_crc_bad;
    logic last_short;
    logic last_trunc;
    logic [7:0] accept_count;
    logic aw_full;
    logic [ADDR_WIDTH-1:0] aw_addr;
    logic w_full;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } erf_state_t;

  erf_state_t state_reg;
  erf_state_t state_next;

  ////////////////////////////////////////////////////////////////////////////
  // One byte of reflected CRC-32, least significant bit first as on the wire.
  function automatic logic [31:0] erf_crc_byte(input logic [31:0] crc_in, input logic [7:0] data);
    logic [31:0] c;
    c = crc_in ^ {24'h00_0000, data};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ ERF_CRC_POLY_REFL) : (c >> 1);
    end
    return c;
  endfunction : erf_crc_byte

  // Byte-enable merge of a write into an old register value.
  function automatic logic [31:0] erf_merge(input logic [31:0] old, input logic [31:0] data, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = data[8*b +: 8];
      end
    end
    return r;
  endfunction : erf_merge

  ////////////////////////////////////////////////////////////////////////////
  // Per-frame datapath and verdict terms.
  logic byte_taken;
  logic [15:0] count_upd;
  logic [31:0] crc_upd;
  logic [47:0] dest_upd;
  logic crc_bad;
  logic is_short;
  logic is_group;
  logic is_bcast;
  logic is_local;
  logic mode_cond;
  logic pattern_hit;
  logic collect_hit;
  logic reject_hit;
  logic address_hit;
  logic accept;
  logic [31:0] read_value;
  logic read_ok;
  logic [31:0] write_old;
  logic [31:0] write_new;
  logic write_ok;

  // Bytes beyond the maximum length are dropped from the CRC, which makes an oversize frame fail.
  always_comb begin
    byte_taken = rx_valid && (state_reg.byte_count < state_reg.max_frame_length);
    count_upd = state_reg.byte_count;
    crc_upd = (state_reg.byte_count == 16'h0000) ? ERF_CRC_INIT : state_reg.crc;
    dest_upd = state_reg.dest;
    if (byte_taken) begin
      crc_upd = erf_crc_byte(crc_upd, rx_data);
      count_upd = state_reg.byte_count + 16'h0001;
      if (state_reg.byte_count < ERF_DA_BYTES) begin
        dest_upd[8*state_reg.byte_count[2:0] +: 8] = rx_data;
      end
    end
  end

  // Classification of the finished frame; the CRC over data plus check bytes leaves a fixed residue.
  always_comb begin
    crc_bad = (crc_upd != ERF_CRC_RESIDUE);
    is_short = (count_upd <= ERF_DA_BYTES + ERF_SHORT_MAX_LEN);
    is_group = dest_upd[0];
    is_bcast = &dest_upd;
    is_local = (dest_upd == state_reg.station_address);
  end

  // Pattern mode condition; reserved codes and the off code never accept.
  always_comb begin
    case (erf_pmode_t'(state_reg.rx_filter_control[ERF_BIT_MODE_LO +: 4]))
      ERF_PM_ANY: mode_cond = 1'b1;
      ERF_PM_LOCAL: mode_cond = is_local;
      ERF_PM_NOT_LOCAL: mode_cond = !is_local;
      ERF_PM_GROUP: mode_cond = is_group;
      ERF_PM_NOT_GROUP: mode_cond = !is_group;
      ERF_PM_BCAST: mode_cond = is_bcast;
      ERF_PM_NOT_BCAST: mode_cond = !is_bcast;
      ERF_PM_HASH: mode_cond = hash_hit;
      ERF_PM_WAKE: mode_cond = wake_hit;
      default: mode_cond = 1'b0;
    endcase
    pattern_hit = mode_cond && (pattern_checksum_match ^ state_reg.rx_filter_control[ERF_BIT_PATTERN_INVERT]);
  end

  // Priority chain: error collection, then error rejection, then the collection filters.
  always_comb begin
    collect_hit = (state_reg.rx_filter_control[ERF_BIT_CRC_COLLECT] && crc_bad)
      || (state_reg.rx_filter_control[ERF_BIT_SHORT_COLLECT] && is_short);
    reject_hit = (state_reg.rx_filter_control[ERF_BIT_CRC_REJECT] && crc_bad)
      || (state_reg.rx_filter_control[ERF_BIT_SHORT_REJECT] && is_short);
    address_hit = (state_reg.rx_filter_control[ERF_BIT_LOCAL_UNICAST] && is_local)
      || (state_reg.rx_filter_control[ERF_BIT_FOREIGN_UNICAST] && !is_group && !is_local)
      || (state_reg.rx_filter_control[ERF_BIT_GROUP_ADDRESS] && is_group)
      || (state_reg.rx_filter_control[ERF_BIT_ALL_STATIONS] && is_bcast)
      || (state_reg.rx_filter_control[ERF_BIT_HASH_ENABLE] && hash_hit)
      || (state_reg.rx_filter_control[ERF_BIT_WAKE_ENABLE] && wake_hit)
      || pattern_hit;
    // A frame nobody accepts falls through to discard.
    accept = collect_hit || (!reject_hit && address_hit);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read decode; unmapped words answer with a slave error and zero data.
  always_comb begin
    read_value = 32'h0000_0000;
    read_ok = 1'b1;
    case (s_axi_araddr[7:0])
      ERF_OFS_FILTER_CONTROL: read_value = {16'h0000, state_reg.rx_filter_control};
      ERF_OFS_STATION_LO: read_value = state_reg.station_address[31:0];
      ERF_OFS_STATION_HI: read_value = {16'h0000, state_reg.station_address[47:32]};
      ERF_OFS_MAX_FRAME_LENGTH: read_value = {16'h0000, state_reg.max_frame_length};
      ERF_OFS_STATUS: read_value = {16'h0000, state_reg.accept_count, 4'h0, state_reg.last_trunc,
        state_reg.last_short, state_reg.last_crc_bad, state_reg.verdict_accept};
      default: read_ok = 1'b0;
    endcase
  end

  // Register write decode of the held address.
  always_comb begin
    write_old = 32'h0000_0000;
    write_ok = 1'b1;
    case (state_reg.aw_addr[7:0])
      ERF_OFS_FILTER_CONTROL: write_old = {16'h0000, state_reg.rx_filter_control};
      ERF_OFS_STATION_LO: write_old = state_reg.station_address[31:0];
      ERF_OFS_STATION_HI: write_old = {16'h0000, state_reg.station_address[47:32]};
      ERF_OFS_MAX_FRAME_LENGTH: write_old = {16'h0000, state_reg.max_frame_length};
      default: write_ok = 1'b0;
    endcase
    write_new = erf_merge(write_old, state_reg.w_data, state_reg.w_strb);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic for frame tracking and the bus slave.
  always_comb begin
    state_next = state_reg;
    state_next.verdict_valid = 1'b0;
    // Frame bytes.
    if (rx_valid) begin
      state_next.crc = crc_upd;
      state_next.dest = dest_upd;
      state_next.byte_count = count_upd;
      state_next.trunc = state_reg.trunc || !byte_taken;
    end
    // Verdict once the last check byte is in; the byte count and truncation flag restart for the next frame.
    if (rx_valid && rx_last) begin
      state_next.verdict_valid = 1'b1;
      state_next.verdict_accept = accept;
      state_next.last_crc_bad = crc_bad;
      state_next.last_short = is_short;
      state_next.last_trunc = state_reg.trunc || !byte_taken;
      state_next.accept_count = state_reg.accept_count + {7'h00, accept};
      state_next.byte_count = 16'h0000;
      state_next.trunc = 1'b0;
    end
    // Write address and data may come in either order.
    if (s_axi_awvalid && state_reg.awready) begin
      state_next.aw_full = 1'b1;
      state_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && state_reg.wready) begin
      state_next.w_full = 1'b1;
      state_next.w_data = s_axi_wdata;
      state_next.w_strb = s_axi_wstrb;
    end
    // Commit when both halves are held; the control field keeps bit 13 at zero.
    if (state_reg.aw_full && state_reg.w_full && !state_reg.bvalid) begin
      state_next.aw_full = 1'b0;
      state_next.w_full = 1'b0;
      state_next.bvalid = 1'b1;
      state_next.bresp = write_ok ? ERF_RESP_OKAY : ERF_RESP_SLVERR;
      case (state_reg.aw_addr[7:0])
        ERF_OFS_FILTER_CONTROL: state_next.rx_filter_control = write_new[15:0] & ERF_CONTROL_WMASK;
        ERF_OFS_STATION_LO: state_next.station_address[31:0] = write_new;
        ERF_OFS_STATION_HI: state_next.station_address[47:32] = write_new[15:0];
        ERF_OFS_MAX_FRAME_LENGTH: state_next.max_frame_length = write_new[15:0];
        default: state_next.bresp = ERF_RESP_SLVERR;
      endcase
    end
    if (state_reg.bvalid && s_axi_bready) begin
      state_next.bvalid = 1'b0;
    end
    // Ready is withheld while a half is held or a response is pending.
    state_next.awready = !state_next.aw_full && !state_next.bvalid && !(state_reg.awready && s_axi_awvalid);
    state_next.wready = !state_next.w_full && !state_next.bvalid && !(state_reg.wready && s_axi_wvalid);
    // Reads answer one cycle after the address is taken.
    if (s_axi_arvalid && state_reg.arready) begin
      state_next.rvalid = 1'b1;
      state_next.rdata = read_value;
      state_next.rresp = read_ok ? ERF_RESP_OKAY : ERF_RESP_SLVERR;
    end else if (state_reg.rvalid && s_axi_rready) begin
      state_next.rvalid = 1'b0;
    end
    state_next.arready = !state_next.rvalid && !(state_reg.arready && s_axi_arvalid);
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; reset brings the power-up filter set.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= '0;
      state_reg.rx_filter_control <= ERF_CONTROL_RESET;
      state_reg.max_frame_length <= MAX_FRAME_DEFAULT;
      state_reg.crc <= ERF_CRC_INIT;
      state_reg.awready <= 1'b1;
      state_reg.wready <= 1'b1;
      state_reg.arready <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from the state register.
  assign s_axi_awready = state_reg.awready;
  assign s_axi_wready = state_reg.wready;
  assign s_axi_bvalid = state_reg.bvalid;
  assign s_axi_bresp = state_reg.bresp;
  assign s_axi_arready = state_reg.arready;
  assign s_axi_rvalid = state_reg.rvalid;
  assign s_axi_rresp = state_reg.rresp;
  assign s_axi_rdata = state_reg.rdata;
  assign verdict_valid = state_reg.verdict_valid;
  assign verdict_accept = state_reg.verdict_accept;

endmodule : erf_filter

// ### verilog/erf_pkg.sv
// Package with register map, field positions, reset values and constants of the receive frame filter.
package erf_pkg;

  // Register byte offsets on the AXI4-Lite bus.
  localparam logic [7:0] ERF_OFS_FILTER_CONTROL = 8'h00;
  localparam logic [7:0] ERF_OFS_STATION_LO = 8'h04;
  localparam logic [7:0] ERF_OFS_STATION_HI = 8'h08;
  localparam logic [7:0] ERF_OFS_MAX_FRAME_LENGTH = 8'h0C;
  localparam logic [7:0] ERF_OFS_STATUS = 8'h10;

  // Field positions inside rx_filter_control.
  localparam int ERF_BIT_ALL_STATIONS = 0;
  localparam int ERF_BIT_GROUP_ADDRESS = 1;
  localparam int ERF_BIT_FOREIGN_UNICAST = 2;
  localparam int ERF_BIT_LOCAL_UNICAST = 3;
  localparam int ERF_BIT_SHORT_REJECT = 4;
  localparam int ERF_BIT_SHORT_COLLECT = 5;
  localparam int ERF_BIT_CRC_REJECT = 6;
  localparam int ERF_BIT_CRC_COLLECT = 7;
  localparam int ERF_BIT_MODE_LO = 8;
  localparam int ERF_BIT_PATTERN_INVERT = 12;
  localparam int ERF_BIT_WAKE_ENABLE = 14;
  localparam int ERF_BIT_HASH_ENABLE = 15;

  // Writable bits of rx_filter_control; bit 13 is unimplemented and reads zero.
  localparam logic [15:0] ERF_CONTROL_WMASK = 16'hDFFF;
  // Power-up value: CRC reject, short reject, local unicast and broadcast on.
  localparam logic [15:0] ERF_CONTROL_RESET = 16'h0059;
  localparam logic [15:0] ERF_MAX_FRAME_RESET = 16'h05EE;

  // Pattern mode encodings.
  typedef enum logic [3:0] {
    ERF_PM_OFF = 4'b0000,
    ERF_PM_ANY = 4'b0001,
    ERF_PM_LOCAL = 4'b0010,
    ERF_PM_NOT_LOCAL = 4'b0011,
    ERF_PM_GROUP = 4'b0100,
    ERF_PM_NOT_GROUP = 4'b0101,
    ERF_PM_BCAST = 4'b0110,
    ERF_PM_NOT_BCAST = 4'b0111,
    ERF_PM_HASH = 4'b1000,
    ERF_PM_WAKE = 4'b1001
  } erf_pmode_t;

  // Frame layout and CRC constants.
  localparam logic [15:0] ERF_DA_BYTES = 16'h0006;
  localparam logic [15:0] ERF_SHORT_MAX_LEN = 16'h003F;
  localparam logic [31:0] ERF_CRC_INIT = 32'hFFFF_FFFF;
  localparam logic [31:0] ERF_CRC_POLY_REFL = 32'hEDB8_8320;
  localparam logic [31:0] ERF_CRC_RESIDUE = 32'hDEBB_20E3;

  // AXI responses.
  localparam logic [1:0] ERF_RESP_OKAY = 2'b00;
  localparam logic [1:0] ERF_RESP_SLVERR = 2'b10;

endpackage : erf_pkg
